// [design/itw_consts.svh]
`ifndef ITW_CONSTS_SVH
`define ITW_CONSTS_SVH

// Register byte offsets on the bus.
`define ITW_OFS_IVCTL 5'h00
`define ITW_OFS_CTL2 5'h04
`define ITW_OFS_WDCTL 5'h08
`define ITW_OFS_WDCLR 5'h0C
`define ITW_OFS_STAT 5'h10

// Reset values.
`define ITW_RST_IVCTL 4'hF
`define ITW_RST_CTL2 3'h7
`define ITW_RST_WDCTL 4'hF

// Field positions.
`define ITW_IV_RESTART 3
`define ITW_C2_MASK 0
`define ITW_C2_CLKSEL 1
`define ITW_C2_BYPASS 2
`define ITW_WD_LOCK 3
`define ITW_WD_RUN 2

// Interval masks, ratio minus one, for interval codes 0 to 7.
`define ITW_IV_M0 14'h0001
`define ITW_IV_M1 14'h0003
`define ITW_IV_M2 14'h0007
`define ITW_IV_M3 14'h000F
`define ITW_IV_M4 14'h001F
`define ITW_IV_M5 14'h00FF
`define ITW_IV_M6 14'h07FF
`define ITW_IV_M7 14'h3FFF

// Watchdog tap masks: reset delay over eight counter steps.
`define ITW_WD_M0 14'h003F
`define ITW_WD_M1 14'h00FF
`define ITW_WD_M2 14'h07FF
`define ITW_WD_M3 14'h3FFF

// Clock management path divides its source by this last count plus one.
`define ITW_CM_DIV_LAST 4'hF
`define ITW_WD_LAST 3'h7

`endif

// [design/itw_pkg.sv]
package itw_pkg;
  // Divider chain word and watchdog count.
  typedef logic [13:0] itw_div_t;
  typedef logic [2:0] itw_wdcnt_t;
  // Source that clocks the divider chain.
  typedef enum {ITW_SRC_SYS, ITW_SRC_SUB} itw_src_t;
endpackage

// [design/itw_wd_if.sv]
`timescale 1ns/10ps
interface itw_wd_if;
  import itw_pkg::*;
  logic tick;
  logic clear;
  logic active;
  logic overflow;
  itw_wdcnt_t count;
  modport ctl (output tick, output clear, output active, input overflow, input count);
  modport wd (input tick, input clear, input active, output overflow, output count);
endinterface

// [design/itw_watchdog.sv]
`timescale 1ns/10ps
`include "itw_consts.svh"
module itw_watchdog
  import itw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  itw_wd_if.wd wd
);
  itw_wdcnt_t cnt_q;
  logic ovf_q;

  // Three-bit counter stepped by its own divider tap.
  always_ff @(posedge clk_i) begin
    if (rst_i || !wd.active) begin
      cnt_q <= '0;
    end else if (wd.clear) begin
      cnt_q <= '0;
    end else if (wd.tick) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Overflow pulse when the last count steps over.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= wd.active && !wd.clear && wd.tick && (cnt_q == `ITW_WD_LAST);
    end
  end

  assign wd.count = cnt_q;
  assign wd.overflow = ovf_q;
endmodule

// [design/itw_timer.sv]
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`include "itw_consts.svh"
module itw_timer
  import itw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sub_clock_i,
  input wire logic cm_clock_i,
  input wire logic cm_select_i,
  input wire logic sleep_i,
  output logic divider_output_o,
  output logic prescale_tick_o,
  output logic periodic_irq_o,
  output logic sys_reset_o
);
  localparam int NSYNC = 2;

  itw_wd_if wd_bus ();

  // Pin synchronisers: index 0 is the sub-clock pin, 1 the clock management pin.
  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] pin_q;
  logic [NSYNC-1:0] pin_prev_q;
  logic [NSYNC-1:0] pin_rise;

  assign pin_in = {cm_clock_i, sub_clock_i};

  // Each pin passes three flops; a change counts once stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
          pin_prev_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
          pin_prev_q[g] <= pin_q[g];
        end
      end
      assign pin_rise[g] = pin_q[g] && !pin_prev_q[g];
    end
  endgenerate

  // Registers.
  logic [3:0] ivctl_q;
  logic [2:0] ctl2_q;
  logic [3:0] wdctl_q;
  logic [3:0] cmdiv_q;
  itw_div_t div_q;
  itw_div_t div_inc;
  logic ack_q;
  logic [31:0] rdat_q;
  logic out_q;
  logic tick_o_q;
  logic irq_q;
  logic rst_o_q;

  // Bus decode; writes and read side effects land on the acknowledging edge.
  logic req;
  logic acc;
  logic wr_en;
  logic wr_ivctl;
  logic wr_ctl2;
  logic wr_wdctl;
  logic rd_wdclr;
  logic restart_ok;

  assign req = wb_cyc_i && wb_stb_i;
  assign acc = req && ack_q;
  assign wr_en = acc && wb_we_i && wb_sel_i[0];
  assign wr_ivctl = wr_en && (wb_adr_i == `ITW_OFS_IVCTL);
  assign wr_ctl2 = wr_en && (wb_adr_i == `ITW_OFS_CTL2);
  assign wr_wdctl = wr_en && (wb_adr_i == `ITW_OFS_WDCTL);
  assign rd_wdclr = acc && !wb_we_i && (wb_adr_i == `ITW_OFS_WDCLR);
  assign restart_ok = wr_ivctl && wb_dat_i[`ITW_IV_RESTART]
    && wdctl_q[`ITW_WD_LOCK];

  // Divider source: sub-clock edges or every system clock cycle.
  itw_src_t src;
  logic sub_tick;
  logic div_tick;

  assign src = ctl2_q[`ITW_C2_CLKSEL] ? ITW_SRC_SUB : ITW_SRC_SYS;
  assign sub_tick = cm_select_i ? (pin_rise[1] && (cmdiv_q == `ITW_CM_DIV_LAST)) : pin_rise[0];
  assign div_tick = (src == ITW_SRC_SUB) ? sub_tick : 1'b1;
  assign div_inc = div_q + {13'h0000, div_tick};

  // Clock management source is divided by sixteen before it acts as sub-clock.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmdiv_q <= '0;
    end else if (pin_rise[1]) begin
      cmdiv_q <= cmdiv_q + 4'h1;
    end
  end

  // Interval control register: settings update, restart only when permitted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ivctl_q <= `ITW_RST_IVCTL;
    end else if (wr_ivctl) begin
      ivctl_q <= wb_dat_i[3:0];
    end
  end

  // Control register two: interrupt mask, clock select, bypass.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl2_q <= `ITW_RST_CTL2;
    end else if (wr_ctl2) begin
      ctl2_q <= wb_dat_i[2:0];
    end
  end

  // Watchdog control: once the lock bit is cleared only a reset sets it again.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdctl_q <= `ITW_RST_WDCTL;
    end else if (wr_wdctl) begin
      wdctl_q[`ITW_WD_LOCK] <= wdctl_q[`ITW_WD_LOCK] && wb_dat_i[`ITW_WD_LOCK];
      wdctl_q[`ITW_WD_RUN] <= wb_dat_i[`ITW_WD_RUN];
      wdctl_q[1:0] <= wb_dat_i[1:0];
    end
  end

  // Divider chain counts from reset on its own; a permitted restart zeroes it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if (restart_ok) begin
      div_q <= '0;
    end else begin
      div_q <= div_inc;
    end
  end

  // Interval tap: the event falls where the selected low stages are all ones.
  itw_div_t iv_mask;
  itw_div_t wd_mask;
  logic iv_event;
  logic iv_level;
  logic wd_event;

  always_comb begin
    case (ivctl_q[2:0])
      3'h0: iv_mask = `ITW_IV_M0;
      3'h1: iv_mask = `ITW_IV_M1;
      3'h2: iv_mask = `ITW_IV_M2;
      3'h3: iv_mask = `ITW_IV_M3;
      3'h4: iv_mask = `ITW_IV_M4;
      3'h5: iv_mask = `ITW_IV_M5;
      3'h6: iv_mask = `ITW_IV_M6;
      3'h7: iv_mask = `ITW_IV_M7;
      default: iv_mask = `ITW_IV_M7;
    endcase
  end

  // Watchdog tap is separate from the interval tap.
  always_comb begin
    case (wdctl_q[1:0])
      2'h0: wd_mask = `ITW_WD_M0;
      2'h1: wd_mask = `ITW_WD_M1;
      2'h2: wd_mask = `ITW_WD_M2;
      2'h3: wd_mask = `ITW_WD_M3;
      default: wd_mask = `ITW_WD_M3;
    endcase
  end

  assign iv_event = div_tick && !restart_ok && ((div_q & iv_mask) == iv_mask);
  assign iv_level = |(div_q & (iv_mask & ~(iv_mask >> 1)));
  assign wd_event = div_tick && ((div_q & wd_mask) == wd_mask);

  // Watchdog active when locked, or when unlocked with the run bit low.
  logic wd_active;
  assign wd_active = !wdctl_q[`ITW_WD_LOCK] || !wdctl_q[`ITW_WD_RUN];
  assign wd_bus.tick = wd_event;
  assign wd_bus.clear = rd_wdclr;
  assign wd_bus.active = wd_active;

  itw_watchdog u_wd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wd(wd_bus)
  );

  // Synchronised timer output, forced low in sleep; bypass picks the path.
  always_ff @(posedge clk_i) begin
    if (rst_i || sleep_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= ctl2_q[`ITW_C2_BYPASS] ? iv_level : pin_q[0];
    end
  end

  // Prescaler tick for other timers and the serial interface.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o_q <= 1'b0;
    end else begin
      tick_o_q <= iv_event;
    end
  end

  // Periodic interrupt pulse gated by the mask, also in sleep.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= iv_event && !ctl2_q[`ITW_C2_MASK];
    end
  end

  // System reset pulse from watchdog overflow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_o_q <= 1'b0;
    end else begin
      rst_o_q <= wd_bus.overflow;
    end
  end

  // Acknowledge one cycle after the request, then drop; read data comes with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= req && !ack_q;
      rdat_q <= '0;
      if (req && !ack_q && !wb_we_i) begin
        case (wb_adr_i)
          `ITW_OFS_CTL2: rdat_q[2:0] <= ctl2_q;
          `ITW_OFS_WDCTL: rdat_q[3:0] <= wdctl_q;
          `ITW_OFS_WDCLR: rdat_q[2:0] <= wd_bus.count;
          `ITW_OFS_STAT: rdat_q[4:0] <= {wd_bus.count, wd_active, out_q};
          default: rdat_q <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign divider_output_o = out_q;
  assign prescale_tick_o = tick_o_q;
  assign periodic_irq_o = irq_q;
  assign sys_reset_o = rst_o_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_restart_clears;
    (wr_ivctl && wb_dat_i[`ITW_IV_RESTART] && wdctl_q[`ITW_WD_LOCK]) |=> (div_q == '0);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear");

  property p_locked_no_restart;
    (wr_ivctl && !wdctl_q[`ITW_WD_LOCK]) |=> (div_q == $past(div_inc));
  endproperty
  a_locked_no_restart: assert property (p_locked_no_restart)
    else $error("locked restart");

  property p_plain_write;
    (wr_ivctl && !wb_dat_i[`ITW_IV_RESTART]) |=> (ivctl_q == $past(wb_dat_i[3:0]))
      && (div_q == $past(div_inc));
  endproperty
  a_plain_write: assert property (p_plain_write)
    else $error("plain write misbehaved");

  property p_sleep_low;
    sleep_i |=> !divider_output_o;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("output high in sleep");

  property p_irq_cause;
    periodic_irq_o |-> $past(iv_event) && !$past(ctl2_q[`ITW_C2_MASK]);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without cause");

  property p_wd_reset;
    (wd_bus.overflow && !rst_i) |=> sys_reset_o;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("overflow gave no reset");

  property p_wd_clear;
    rd_wdclr |=> (wd_bus.count == '0);
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("clear read ignored");

  property p_lock_sticky;
    !wdctl_q[`ITW_WD_LOCK] |=> !wdctl_q[`ITW_WD_LOCK] && wd_active;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock released");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_src_sys;
    (!ctl2_q[`ITW_C2_CLKSEL] && !restart_ok) |=> (div_q == $past(div_q) + 14'h0001);
  endproperty
  a_src_sys: assert property (p_src_sys) else $error("system clock not counted");
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, e, m;
  logic sub_clock_i = 1'b0;
  logic cm_clock_i = 1'b0;
  logic cm_select_i, sleep_i, divider_output_o, prescale_tick_o, periodic_irq_o, sys_reset_o;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int num_errors = 0;
  int n_tests = 0;
  int k = 0;
  int n_rst = 0;
  int c, d1, nt, ni, nd;
  int ratio[8] = '{2, 4, 8, 16, 32, 256, 2048, 16384};
  int wdd[3] = '{512, 2048, 16384};
  time t0;

  itw_timer itw_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sub_clock_i(sub_clock_i), .cm_clock_i(cm_clock_i), .cm_select_i(cm_select_i),
    .sleep_i(sleep_i), .divider_output_o(divider_output_o),
    .prescale_tick_o(prescale_tick_o), .periodic_irq_o(periodic_irq_o),
    .sys_reset_o(sys_reset_o));

  // System clock of 50 ns period.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Slow pins: sub-clock period 16 cycles, source pin period 4 cycles.
  always @(posedge clk_i) begin
    k <= k + 1;
    if (k[2:0] == 3'h7) sub_clock_i <= ~sub_clock_i;
    if (k[0]) cm_clock_i <= ~cm_clock_i;
    if (sys_reset_o === 1'b1) n_rst <= n_rst + 1;
  end

  // Compares each bus answer with the oldest note.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 0) check(wb_dat_o & m, e & m);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail();
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    close_out();
  endtask

  // One classic bus cycle; a zero mask means the answer is not compared.
  task automatic bus(input logic [4:0] a, input logic w, input logic [3:0] d,
                     input logic [31:0] x, input logic [31:0] mk, input logic [3:0] s);
    int t;
    t = 0;
    exp_q.push_back(x);
    msk_q.push_back(mk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {28'($urandom()), d};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (t >= 20) fail();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Waits for a tick (0), an interrupt (1) or a system reset (2).
  task automatic wait_ev(input int s, output int n);
    logic v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      v = (s == 0) ? prescale_tick_o : (s == 1) ? periodic_irq_o : sys_reset_o;
    end while (v !== 1'b1 && n < 40000);
    if (n >= 40000) fail();
  endtask

  // Counts ticks, interrupts and high output cycles over 64 cycles.
  task automatic watch();
    nt = 0;
    ni = 0;
    nd = 0;
    repeat (64) begin
      @(posedge clk_i);
      nt += int'(prescale_tick_o === 1'b1);
      ni += int'(periodic_irq_o === 1'b1);
      nd += int'(divider_output_o === 1'b1);
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h5EEE));
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cm_select_i, sleep_i} = 6'h20;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    do_reset();
    bus(5'h04, 0, 0, 32'h7, '1, 4'hF);
    bus(5'h08, 0, 0, 32'hF, '1, 4'hF);
    bus(5'h00, 0, 0, 32'h0, '1, 4'hF);
    bus(5'h14, 0, 0, 32'h0, '1, 4'hF);
    bus(5'h10, 0, 0, 32'h0, 32'h1E, 4'hF);
    bus(5'h04, 1, 4'h0, 0, 0, 4'hE);
    bus(5'h04, 0, 0, 32'h7, '1, 4'hF);
    // Interval codes without restart, interrupt enabled, system clock.
    bus(5'h04, 1, 4'h0, 0, 0, 4'hF);
    for (int i = 0; i < 8; i++) begin
      bus(5'h00, 1, {1'b0, 3'(i)}, 0, 0, 4'hF);
      wait_ev(1, c);
      wait_ev(1, c);
      check(32'(c), 32'(ratio[i]));
    end
    bus(5'h00, 1, 4'h0, 0, 0, 4'hF);
    bus(5'h04, 1, 4'h1, 0, 0, 4'hF);
    watch();
    check(32'(nt), 32'd32);
    check(32'(ni), 32'd0);
    bus(5'h04, 1, 4'h4, 0, 0, 4'hF);
    watch();
    check(32'(nd), 32'd32);
    sleep_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    watch();
    check(32'(nd), 32'd0);
    check(32'(ni), 32'd32);
    sleep_i <= 1'b0;
    // Sub-clock from the pin, then from the divided source pin.
    bus(5'h04, 1, 4'h2, 0, 0, 4'hF);
    repeat (2) wait_ev(0, c);
    wait_ev(0, c);
    check(32'(c), 32'd32);
    cm_select_i <= 1'b1;
    repeat (3) wait_ev(0, c);
    wait_ev(0, c);
    check(32'(c), 32'd128);
    cm_select_i <= 1'b0;
    // Restart at two random phases gives the same first interval.
    bus(5'h04, 1, 4'h0, 0, 0, 4'hF);
    bus(5'h00, 1, 4'h5, 0, 0, 4'hF);
    for (int j = 0; j < 2; j++) begin
      wait_ev(0, c);
      repeat ($urandom_range(10, 200)) @(posedge clk_i);
      bus(5'h00, 1, 4'hD, 0, 0, 4'hF);
      wait_ev(0, c);
      if (j == 0) d1 = c;
    end
    check(32'(c), 32'(d1));
    check(32'(d1), 32'd256);
    wait_ev(0, c);
    t0 = $time;
    repeat ($urandom_range(10, 200)) @(posedge clk_i);
    bus(5'h00, 1, 4'h5, 0, 0, 4'hF);
    wait_ev(0, c);
    check(32'(($time - t0) / 50), 32'd256);
    // Watchdog kept alive by clear reads, then stopped.
    bus(5'h08, 1, 4'h8, 0, 0, 4'hF);
    bus(5'h10, 0, 0, 32'h2, 32'h2, 4'hF);
    repeat (4) begin
      repeat (300) @(posedge clk_i);
      bus(5'h0C, 0, 0, 0, 0, 4'hF);
    end
    bus(5'h08, 1, 4'hC, 0, 0, 4'hF);
    bus(5'h10, 0, 0, 32'h0, 32'h2, 4'hF);
    repeat (1200) @(posedge clk_i);
    check(32'(n_rst), 32'd0);
    // Overflow delay for each short watchdog interval.
    for (int i = 0; i < 3; i++) begin
      // Reset brings back the sub-clock select, so count the system clock again.
      bus(5'h04, 1, 4'h1, 0, 0, 4'hF);
      bus(5'h08, 1, {2'b10, 2'(i)}, 0, 0, 4'hF);
      wait_ev(2, c);
      check(32'(c > wdd[i] * 7 / 8 && c < wdd[i] + 8), 32'd1);
      do_reset();
    end
    // Locked watchdog ignores the run bit and restart requests.
    bus(5'h04, 1, 4'h0, 0, 0, 4'hF);
    bus(5'h00, 1, 4'h5, 0, 0, 4'hF);
    bus(5'h08, 1, 4'h0, 0, 0, 4'hF);
    bus(5'h08, 1, 4'hC, 0, 0, 4'hF);
    bus(5'h08, 0, 0, 32'h0, 32'h8, 4'hF);
    bus(5'h10, 0, 0, 32'h2, 32'h2, 4'hF);
    wait_ev(0, c);
    t0 = $time;
    bus(5'h0C, 0, 0, 0, 0, 4'hF);
    repeat ($urandom_range(10, 150)) @(posedge clk_i);
    bus(5'h00, 1, 4'hD, 0, 0, 4'hF);
    wait_ev(0, c);
    check(32'(($time - t0) / 50), 32'd256);
    wait_ev(2, c);
    check(32'(c < 520), 32'd1);
    close_out();
  end
endmodule
